// >>> include/vgh_consts.svh
// Offsets, reserved bit patterns, codes and reset values of the gain and line sync registers
`ifndef VGH_CONSTS_SVH
`define VGH_CONSTS_SVH
`define VGH_IDX_GAIN_MODE 8'h2C
`define VGH_IDX_CHROMA_HIGH 8'h2D
`define VGH_IDX_CHROMA_LOW 8'h2E
`define VGH_IDX_LUMA_HIGH 8'h2F
`define VGH_IDX_LUMA_LOW 8'h30
`define VGH_IDX_STORE_HIGH 8'h31
`define VGH_IDX_STORE_LOW 8'h32
`define VGH_IDX_MISC 8'h33
`define VGH_IDX_SYNC_HIGH 8'h34
`define VGH_IDX_SYNC_BEGIN 8'h35
`define VGH_IDX_SYNC_END 8'h36
`define VGH_RSV_MODE 8'h8C
`define VGH_RSV_GAIN_HIGH 8'h30
`define VGH_RSV_STORE_HIGH 8'h70
`define VGH_RSV_MISC 8'hA0
`define VGH_RSV_SYNC_HIGH 8'h0F
`define VGH_RST_SYNC_BEGIN 8'h01
`define VGH_RST_SYNC_END 8'h00
`define VGH_LMODE_MANUAL 3'h0
`define VGH_LMODE_PEAK 3'h5
`define VGH_LMODE_AVERAGE 3'h6
`define VGH_LMODE_FREEZE 3'h7
`define VGH_CMODE_MANUAL 2'h0
`define VGH_CMODE_LUMA 2'h1
`define VGH_CMODE_AUTO 2'h2
`define VGH_CMODE_FREEZE 2'h3
`define VGH_SPEED_FAST 2'h2
`define VGH_SPEED_QUALITY 2'h3
`define VGH_AVG_FIRST 9'h021
`define VGH_AVG_LAST_LONG 9'h136
`define VGH_AVG_LAST_SHORT 9'h10E
`endif

// >>> include/vgh_pkg.sv
// Types shared by the gain and line sync register block
package vgh_pkg;
    typedef logic [11:0] vgh_gain_t;
    typedef logic [9:0] vgh_pos_t;
    typedef logic [7:0] vgh_byte_t;
    typedef logic [8:0] vgh_line_t;
endpackage

// >>> hdl/vgh_apb_decode.sv
// APB access phase decode and word index extraction
`timescale 1ns/1ps
module vgh_apb_decode #(
    parameter int ADDR_W = 12
) (
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic readyQ,
    output logic setupRead,
    output logic writeFire,
    output logic aligned,
    output vgh_pkg::vgh_byte_t wordIdx
);
    import vgh_pkg::*;
    // Answer is prepared during setup so access completes in its first cycle
    assign setupRead = psel && !penable;
    assign writeFire = psel && penable && readyQ && pwrite;
    assign aligned = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:10] == '0);
    assign wordIdx = paddr[9:2];
endmodule

// >>> hdl/vgh_line_sync_gen.sv
// Positioned line sync output counted from the internal sync falling edge
`timescale 1ns/1ps
module vgh_line_sync_gen (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic lineSyncIn,
    input wire logic pixelEn,
    input vgh_pkg::vgh_pos_t beginPos,
    input vgh_pkg::vgh_pos_t endPos,
    output logic lineSyncOut
);
    import vgh_pkg::*;
    logic syncPrev_q;
    logic running_q;
    vgh_pos_t pixCnt_q;
    logic fallEdge;
    logic cntMax;
    vgh_pos_t pixCnt_d;
    logic outActive;
    assign fallEdge = syncPrev_q && !lineSyncIn;
    assign cntMax = (pixCnt_q == '1);
    // Counter saturates so a missing sync edge cannot wrap into a false pulse
    assign pixCnt_d = fallEdge ? '0 : ((pixelEn && !cntMax) ? pixCnt_q + 10'h001 : pixCnt_q);
    assign outActive = running_q && (pixCnt_q >= beginPos) && (pixCnt_q < endPos);
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            syncPrev_q <= 1'b0;
            running_q <= 1'b0;
            pixCnt_q <= '0;
            lineSyncOut <= 1'b0;
        end
        else
        begin
            syncPrev_q <= lineSyncIn;
            running_q <= running_q || fallEdge;
            pixCnt_q <= pixCnt_d;
            lineSyncOut <= outActive;
        end
    end
endmodule

// >>> hdl/vgh_regs.sv
// Gain control and line sync position registers behind an APB slave
`timescale 1ns/1ps
`include "vgh_consts.svh"
module vgh_regs #(
    parameter int ADDR_W = 12
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input vgh_pkg::vgh_gain_t lumaLoopGain,
    input vgh_pkg::vgh_gain_t chromaLoopGain,
    input wire logic [1:0] videoQualityMeasure,
    input wire logic lineSyncIn,
    input wire logic pixelEn,
    output vgh_pkg::vgh_gain_t lumaGainActive,
    output vgh_pkg::vgh_gain_t chromaGainActive,
    output logic [1:0] lumaSpeedCode,
    output logic lumaSpeedValid,
    output logic peakWhiteActive,
    output logic avgVideoActive,
    output logic peakWhitePerField,
    output vgh_pkg::vgh_line_t avgLineFirst,
    output vgh_pkg::vgh_line_t avgLineLast,
    output vgh_pkg::vgh_byte_t maxIrePal,
    output vgh_pkg::vgh_byte_t maxIreNtsc,
    output logic colorKillEn,
    output logic lineSyncOut
);
    import vgh_pkg::*;

    // PAL limit in upper byte, NTSC in lower byte
    function automatic logic [15:0] ireLimits(input logic [2:0] code);
        logic [15:0] lim;
        lim = 16'h6464;
        unique case (code)
            3'h0: lim = 16'h857A;
            3'h1: lim = 16'h7D73;
            3'h2: lim = 16'h786E;
            3'h3: lim = 16'h7369;
            3'h4: lim = 16'h6E64;
            3'h5: lim = 16'h6964;
            3'h6: lim = 16'h6464;
            3'h7: lim = 16'h6464;
        endcase
        return lim;
    endfunction

    function automatic logic isIdx(input vgh_byte_t idx, input vgh_byte_t want);
        return idx == want;
    endfunction

    logic setupRead;
    logic writeFire;
    logic aligned;
    vgh_byte_t wordIdx;
    vgh_byte_t wrByte;

    logic [2:0] lumaMode_q;
    logic [1:0] chromaMode_q;
    vgh_gain_t chromaManual_q;
    logic [1:0] chromaSpeed_q;
    vgh_gain_t lumaManual_q;
    logic [1:0] lumaSpeed_q;
    vgh_gain_t lumaStore_q;
    logic storeUpdateEn_q;
    logic peakWhiteRate_q;
    logic avgLinesSel_q;
    logic [2:0] maxInputLevel_q;
    logic colorKill_q;
    vgh_pos_t syncBegin_q;
    vgh_pos_t syncEnd_q;

    vgh_gain_t lumaGain_d;
    vgh_gain_t chromaGain_d;
    logic [15:0] ireSel;
    logic autoMode;
    logic [1:0] speedSel;
    logic hitMapped;
    vgh_byte_t readByte;
    vgh_gain_t storeView;
    vgh_gain_t manualView;

    vgh_apb_decode #(
        .ADDR_W(ADDR_W)
    ) u_decode (
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .readyQ(pready),
        .setupRead(setupRead),
        .writeFire(writeFire),
        .aligned(aligned),
        .wordIdx(wordIdx)
    );

    assign wrByte = pwdata[7:0];

    logic wrMode;
    logic wrChromaHigh;
    logic wrChromaLow;
    logic wrLumaHigh;
    logic wrLumaLow;
    logic wrStoreHigh;
    logic wrStoreLow;
    logic wrMisc;
    logic wrSyncHigh;
    logic wrSyncBegin;
    logic wrSyncEnd;
    logic wrOk;

    assign wrOk = writeFire && aligned;
    assign wrMode = wrOk && isIdx(wordIdx, `VGH_IDX_GAIN_MODE);
    assign wrChromaHigh = wrOk && isIdx(wordIdx, `VGH_IDX_CHROMA_HIGH);
    assign wrChromaLow = wrOk && isIdx(wordIdx, `VGH_IDX_CHROMA_LOW);
    assign wrLumaHigh = wrOk && isIdx(wordIdx, `VGH_IDX_LUMA_HIGH);
    assign wrLumaLow = wrOk && isIdx(wordIdx, `VGH_IDX_LUMA_LOW);
    assign wrStoreHigh = wrOk && isIdx(wordIdx, `VGH_IDX_STORE_HIGH);
    assign wrStoreLow = wrOk && isIdx(wordIdx, `VGH_IDX_STORE_LOW);
    assign wrMisc = wrOk && isIdx(wordIdx, `VGH_IDX_MISC);
    assign wrSyncHigh = wrOk && isIdx(wordIdx, `VGH_IDX_SYNC_HIGH);
    assign wrSyncBegin = wrOk && isIdx(wordIdx, `VGH_IDX_SYNC_BEGIN);
    assign wrSyncEnd = wrOk && isIdx(wordIdx, `VGH_IDX_SYNC_END);

    // Mode and gain fields
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lumaMode_q <= `VGH_LMODE_MANUAL;
            chromaMode_q <= `VGH_CMODE_MANUAL;
            chromaManual_q <= '0;
            chromaSpeed_q <= 2'h0;
            lumaManual_q <= '0;
            lumaSpeed_q <= 2'h0;
            lumaStore_q <= '0;
            storeUpdateEn_q <= 1'b0;
        end
        else
        begin
            if (wrMode)
            begin
                chromaMode_q <= wrByte[1:0];
                lumaMode_q <= wrByte[6:4];
            end
            if (wrChromaHigh)
            begin
                chromaManual_q[11:8] <= wrByte[3:0];
                chromaSpeed_q <= wrByte[7:6];
            end
            if (wrChromaLow)
            begin
                chromaManual_q[7:0] <= wrByte;
            end
            if (wrLumaHigh)
            begin
                lumaManual_q[11:8] <= wrByte[3:0];
                lumaSpeed_q <= wrByte[7:6];
            end
            if (wrLumaLow)
            begin
                lumaManual_q[7:0] <= wrByte;
            end
            if (wrStoreHigh)
            begin
                lumaStore_q[11:8] <= wrByte[3:0];
                storeUpdateEn_q <= wrByte[7];
            end
            if (wrStoreLow)
            begin
                lumaStore_q[7:0] <= wrByte;
            end
        end
    end

    // Measurement and line sync fields
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            peakWhiteRate_q <= 1'b0;
            avgLinesSel_q <= 1'b0;
            maxInputLevel_q <= 3'h0;
            colorKill_q <= 1'b0;
            syncBegin_q <= {2'h0, `VGH_RST_SYNC_BEGIN};
            syncEnd_q <= {2'h0, `VGH_RST_SYNC_END};
        end
        else
        begin
            if (wrMisc)
            begin
                peakWhiteRate_q <= wrByte[0];
                avgLinesSel_q <= wrByte[1];
                maxInputLevel_q <= wrByte[4:2];
                colorKill_q <= wrByte[6];
            end
            if (wrSyncHigh)
            begin
                syncEnd_q[9:8] <= wrByte[5:4];
                syncBegin_q[9:8] <= wrByte[7:6];
            end
            if (wrSyncBegin)
            begin
                syncBegin_q[7:0] <= wrByte;
            end
            if (wrSyncEnd)
            begin
                syncEnd_q[7:0] <= wrByte;
            end
        end
    end

    // Store overrides the manual value only when surveillance updates are on
    assign manualView = storeUpdateEn_q ? lumaStore_q : lumaManual_q;

    always_comb
    begin
        lumaGain_d = lumaLoopGain;
        unique case (lumaMode_q)
            `VGH_LMODE_MANUAL: lumaGain_d = manualView;
            `VGH_LMODE_FREEZE: lumaGain_d = lumaGainActive;
            default: lumaGain_d = lumaLoopGain;
        endcase
    end

    always_comb
    begin
        chromaGain_d = chromaLoopGain;
        unique case (chromaMode_q)
            `VGH_CMODE_MANUAL: chromaGain_d = chromaManual_q;
            `VGH_CMODE_LUMA: chromaGain_d = lumaGainActive;
            `VGH_CMODE_AUTO: chromaGain_d = chromaLoopGain;
            `VGH_CMODE_FREEZE: chromaGain_d = chromaGainActive;
        endcase
    end

    // Automatic modes are every luma code other than manual and freeze
    assign autoMode = (lumaMode_q != `VGH_LMODE_MANUAL) &&
        (lumaMode_q != `VGH_LMODE_FREEZE);
    // Quality input saturates at fast; its top code would mean quality again
    assign speedSel = (lumaSpeed_q != `VGH_SPEED_QUALITY) ? lumaSpeed_q :
        ((videoQualityMeasure == `VGH_SPEED_QUALITY) ? `VGH_SPEED_FAST :
        videoQualityMeasure);
    assign ireSel = ireLimits(maxInputLevel_q);

    // Derived control outputs, all registered
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lumaGainActive <= '0;
            chromaGainActive <= '0;
            lumaSpeedCode <= 2'h0;
            lumaSpeedValid <= 1'b0;
            peakWhiteActive <= 1'b0;
            avgVideoActive <= 1'b0;
            peakWhitePerField <= 1'b0;
            avgLineFirst <= `VGH_AVG_FIRST;
            avgLineLast <= `VGH_AVG_LAST_LONG;
            maxIrePal <= 8'h85;
            maxIreNtsc <= 8'h7A;
            colorKillEn <= 1'b0;
        end
        else
        begin
            lumaGainActive <= lumaGain_d;
            chromaGainActive <= chromaGain_d;
            lumaSpeedCode <= autoMode ? speedSel : lumaSpeedCode;
            lumaSpeedValid <= autoMode;
            peakWhiteActive <= (lumaMode_q == `VGH_LMODE_PEAK);
            avgVideoActive <= (lumaMode_q == `VGH_LMODE_AVERAGE);
            peakWhitePerField <= peakWhiteRate_q;
            avgLineFirst <= `VGH_AVG_FIRST;
            avgLineLast <= avgLinesSel_q ? `VGH_AVG_LAST_SHORT : `VGH_AVG_LAST_LONG;
            maxIrePal <= ireSel[15:8];
            maxIreNtsc <= ireSel[7:0];
            colorKillEn <= colorKill_q;
        end
    end

    // Store reads back its own value in manual mode, otherwise the gain in use
    assign storeView = (lumaMode_q == `VGH_LMODE_MANUAL) ? lumaStore_q : lumaGainActive;

    assign hitMapped = aligned && (wordIdx >= `VGH_IDX_GAIN_MODE) &&
        (wordIdx <= `VGH_IDX_SYNC_END);

    // Reserved bits read as their printed ones
    always_comb
    begin
        readByte = 8'h00;
        unique case (wordIdx)
            `VGH_IDX_GAIN_MODE: readByte = `VGH_RSV_MODE |
                {1'b0, lumaMode_q, 2'h0, chromaMode_q};
            `VGH_IDX_CHROMA_HIGH: readByte = `VGH_RSV_GAIN_HIGH |
                {chromaSpeed_q, 2'h0, chromaGainActive[11:8]};
            `VGH_IDX_CHROMA_LOW: readByte = chromaGainActive[7:0];
            `VGH_IDX_LUMA_HIGH: readByte = `VGH_RSV_GAIN_HIGH |
                {lumaSpeed_q, 2'h0, lumaGainActive[11:8]};
            `VGH_IDX_LUMA_LOW: readByte = lumaGainActive[7:0];
            `VGH_IDX_STORE_HIGH: readByte = `VGH_RSV_STORE_HIGH |
                {storeUpdateEn_q, 3'h0, storeView[11:8]};
            `VGH_IDX_STORE_LOW: readByte = storeView[7:0];
            `VGH_IDX_MISC: readByte = `VGH_RSV_MISC |
                {1'b0, colorKill_q, 1'b0, maxInputLevel_q, avgLinesSel_q, peakWhiteRate_q};
            `VGH_IDX_SYNC_HIGH: readByte = `VGH_RSV_SYNC_HIGH |
                {syncBegin_q[9:8], syncEnd_q[9:8], 4'h0};
            `VGH_IDX_SYNC_BEGIN: readByte = syncBegin_q[7:0];
            `VGH_IDX_SYNC_END: readByte = syncEnd_q[7:0];
            default: readByte = 8'h00;
        endcase
    end

    // Answer is registered in setup, so every access has no wait states
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= setupRead;
            pslverr <= setupRead && !hitMapped;
            if (setupRead)
            begin
                prdata <= (hitMapped && !pwrite) ? {24'h000000, readByte} : 32'h00000000;
            end
        end
    end

    vgh_line_sync_gen u_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .lineSyncIn(lineSyncIn),
        .pixelEn(pixelEn),
        .beginPos(syncBegin_q),
        .endPos(syncEnd_q),
        .lineSyncOut(lineSyncOut)
    );
endmodule

// >>> testbench/vgh_regs_chk.sv
// Port level checker for the gain and line sync register block
`timescale 1ns/1ps
module vgh_regs_chk (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input logic pready,
    input logic pslverr,
    input vgh_pkg::vgh_gain_t lumaLoopGain,
    input vgh_pkg::vgh_gain_t lumaGainActive,
    input logic [1:0] lumaSpeedCode,
    input logic lumaSpeedValid,
    input logic peakWhiteActive,
    input logic avgVideoActive,
    input vgh_pkg::vgh_line_t avgLineFirst,
    input vgh_pkg::vgh_line_t avgLineLast,
    input vgh_pkg::vgh_byte_t maxIrePal,
    input vgh_pkg::vgh_byte_t maxIreNtsc
);
    import vgh_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    property p_zeroWait;
        psel && !penable |=> pready;
    endproperty
    a_zeroWait: assert property (p_zeroWait) else $error("no ready after setup");
    property p_readyPulse;
        pready |=> !pready;
    endproperty
    a_readyPulse: assert property (p_readyPulse) else $error("ready longer than one cycle");
    property p_errWithReady;
        pslverr |-> pready;
    endproperty
    a_errWithReady: assert property (p_errWithReady) else $error("error without ready");
    // Two cycles, since valid and code register together on a mode change
    property p_speedHold;
        !lumaSpeedValid ##1 !lumaSpeedValid |-> $stable(lumaSpeedCode);
    endproperty
    a_speedHold: assert property (p_speedHold) else $error("speed moved outside auto");
    property p_speedCode;
        lumaSpeedCode != 2'h3;
    endproperty
    a_speedCode: assert property (p_speedCode) else $error("speed code 11 on output");
    property p_maxIre;
        (maxIrePal == 8'h85 && maxIreNtsc == 8'h7A) || (maxIrePal == 8'h7D && maxIreNtsc == 8'h73)
        || (maxIrePal == 8'h78 && maxIreNtsc == 8'h6E) || (maxIrePal == 8'h73 && maxIreNtsc == 8'h69)
        || (maxIreNtsc == 8'h64
        && (maxIrePal == 8'h6E || maxIrePal == 8'h69 || maxIrePal == 8'h64));
    endproperty
    a_maxIre: assert property (p_maxIre) else $error("level pair not in table");
    property p_avgLines;
        avgLineFirst == 9'h021 && (avgLineLast == 9'h136 || avgLineLast == 9'h10E);
    endproperty
    a_avgLines: assert property (p_avgLines) else $error("line range wrong");
    property p_modeExcl;
        peakWhiteActive || avgVideoActive |->
            lumaSpeedValid && !(peakWhiteActive && avgVideoActive);
    endproperty
    a_modeExcl: assert property (p_modeExcl) else $error("mode flags inconsistent");
    property p_loopGain;
        peakWhiteActive || avgVideoActive |-> lumaGainActive == $past(lumaLoopGain);
    endproperty
    a_loopGain: assert property (p_loopGain) else $error("loop gain not in use");
endmodule
bind vgh_regs vgh_regs_chk chk_u (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .lumaLoopGain(lumaLoopGain),
    .lumaGainActive(lumaGainActive), .lumaSpeedCode(lumaSpeedCode),
    .lumaSpeedValid(lumaSpeedValid), .peakWhiteActive(peakWhiteActive),
    .avgVideoActive(avgVideoActive), .avgLineFirst(avgLineFirst), .avgLineLast(avgLineLast),
    .maxIrePal(maxIrePal), .maxIreNtsc(maxIreNtsc));

// >>> testbench/vgh_regs_bench.sv
// Self-checking bench for the gain and line sync register block
`timescale 1ns/1ps
module vgh_regs_bench;
    import vgh_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err;
    vgh_gain_t lumaLoopGain = 12'h000, chromaLoopGain = 12'h000, lumaGainActive, chromaGainActive;
    logic [1:0] videoQualityMeasure = 2'h0, lumaSpeedCode;
    logic lineSyncIn = 1'b1, pixelEn = 1'b1;
    logic lumaSpeedValid, peakWhiteActive, avgVideoActive, peakWhitePerField, colorKillEn;
    logic lineSyncOut;
    vgh_line_t avgLineFirst, avgLineLast;
    vgh_byte_t maxIrePal, maxIreNtsc;
    logic [2:0] k;
    int failures = 0, total_checks = 0, hiA, riseA, hiB, riseB;
    vgh_byte_t rstTab [11] = '{8'h8C, 8'h30, 8'h00, 8'h30, 8'h00, 8'h70, 8'h00, 8'hA0,
        8'h0F, 8'h01, 8'h00};
    vgh_byte_t palTab [8] = '{8'h85, 8'h7D, 8'h78, 8'h73, 8'h6E, 8'h69, 8'h64, 8'h64};
    vgh_byte_t ntscTab [8] = '{8'h7A, 8'h73, 8'h6E, 8'h69, 8'h64, 8'h64, 8'h64, 8'h64};
    vgh_gain_t chrTab [4] = '{12'h4C8, 12'h321, 12'h6E1, 12'h6E1};
    vgh_regs dut_u (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .lumaLoopGain, .chromaLoopGain, .videoQualityMeasure, .lineSyncIn,
        .pixelEn, .lumaGainActive, .chromaGainActive, .lumaSpeedCode, .lumaSpeedValid,
        .peakWhiteActive, .avgVideoActive, .peakWhitePerField, .avgLineFirst, .avgLineLast,
        .maxIrePal, .maxIreNtsc, .colorKillEn, .lineSyncOut);
    initial
    begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    task summarize();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task check(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Request held until pready is seen high at a rising edge
    task xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1)
        begin
            failures++;
            summarize();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input vgh_byte_t idx, input vgh_byte_t d);
        xfer(1'b1, {2'b00, idx, 2'b00}, {24'h0, d});
    endtask
    task rdchk(input vgh_byte_t idx, input vgh_byte_t exp);
        xfer(1'b0, {2'b00, idx, 2'b00}, 32'h0);
        check("read data", {24'h0, exp}, rd);
    endtask
    // Derived outputs lag the register by one cycle, chroma from luma by two
    task settle();
        repeat (3) @(posedge ref_clk);
    endtask
    task lineTest(input logic [9:0] b, input logic [9:0] e, output int hi, output int rise);
        wr(8'h34, {b[9:8], e[9:8], 4'hF});
        wr(8'h35, b[7:0]);
        wr(8'h36, e[7:0]);
        hi = 0;
        rise = -1;
        lineSyncIn <= 1'b1;
        repeat (4) @(posedge ref_clk);
        lineSyncIn <= 1'b0;
        for (int i = 0; i < 400; i++)
        begin
            @(posedge ref_clk);
            if (lineSyncOut === 1'b1)
            begin
                hi++;
                if (rise < 0)
                    rise = i;
            end
        end
    endtask
    initial
    begin
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 11; i++)
            rdchk(8'h2C + i[7:0], rstTab[i]);
        check("sync out", 32'h0, lineSyncOut);
        $display("test reset done");
        lumaLoopGain <= 12'h9B7;
        wr(8'h2F, 8'hB0);
        for (int c = 0; c < 8; c++)
        begin
            k = c[2:0];
            wr(8'h2C, {1'b1, k, 4'hC});
            settle();
            check("speed valid", (c >= 1 && c <= 6), lumaSpeedValid);
            check("peak flag", (c == 5), peakWhiteActive);
            check("avg flag", (c == 6), avgVideoActive);
            check("luma gain", (c == 0) ? 12'h000 : 12'h9B7, lumaGainActive);
            if (lumaSpeedValid === 1'b1)
                check("speed code", 2'h2, lumaSpeedCode);
        end
        lumaLoopGain <= 12'h123;
        wr(8'h2F, 8'h30);
        settle();
        check("frozen gain", 12'h9B7, lumaGainActive);
        check("speed held", 2'h2, lumaSpeedCode);
        wr(8'h2C, 8'hDC);
        settle();
        check("speed slow", 2'h0, lumaSpeedCode);
        wr(8'h2F, 8'h70);
        settle();
        check("speed medium", 2'h1, lumaSpeedCode);
        wr(8'h2F, 8'hF0);
        settle();
        check("speed quality", 2'h0, lumaSpeedCode);
        videoQualityMeasure <= 2'h3;
        settle();
        check("speed quality top", 2'h2, lumaSpeedCode);
        rdchk(8'h30, 8'h23);
        rdchk(8'h32, 8'h23);
        rdchk(8'h2F, 8'hF1);
        $display("test luma modes done");
        wr(8'h2C, 8'h8C);
        wr(8'h2F, 8'h3A);
        wr(8'h30, 8'h5C);
        settle();
        check("manual gain", 12'hA5C, lumaGainActive);
        rdchk(8'h30, 8'h5C);
        wr(8'h31, 8'h03);
        wr(8'h32, 8'h21);
        settle();
        check("store off", 12'hA5C, lumaGainActive);
        rdchk(8'h32, 8'h21);
        wr(8'h31, 8'h83);
        settle();
        check("store on", 12'h321, lumaGainActive);
        rdchk(8'h31, 8'hF3);
        $display("test store done");
        chromaLoopGain <= 12'h6E1;
        wr(8'h2D, 8'h34);
        wr(8'h2E, 8'hC8);
        for (int c = 0; c < 4; c++)
        begin
            wr(8'h2C, 8'h8C | c[7:0]);
            settle();
            check("chroma gain", chrTab[c], chromaGainActive);
        end
        chromaLoopGain <= 12'h111;
        settle();
        check("chroma frozen", 12'h6E1, chromaGainActive);
        rdchk(8'h2E, 8'hE1);
        $display("test chroma done");
        for (int c = 0; c < 8; c++)
        begin
            k = c[2:0];
            wr(8'h33, {1'b1, k[2], 1'b1, k, k[1], k[0]});
            settle();
            check("pal level", palTab[c], maxIrePal);
            check("ntsc level", ntscTab[c], maxIreNtsc);
            check("pw rate", k[0], peakWhitePerField);
            check("last line", k[1] ? 9'h10E : 9'h136, avgLineLast);
            check("first line", 9'h021, avgLineFirst);
            check("colour kill", k[2], colorKillEn);
            rdchk(8'h33, {1'b1, k[2], 1'b1, k, k[1], k[0]});
        end
        $display("test misc done");
        xfer(1'b0, 12'h100, 32'h0);
        check("unmapped err", 1'b1, err);
        check("unmapped data", 32'h0, rd);
        // Target reads back its stored value, so a landed write would show
        xfer(1'b1, 12'h0D5, 32'hFF);
        check("misaligned err", 1'b1, err);
        rdchk(8'h35, 8'h01);
        $display("test refusal done");
        lineTest(10'h003, 10'h006, hiA, riseA);
        lineTest(10'h103, 10'h106, hiB, riseB);
        check("sync length", 3, hiA);
        check("sync length high", 3, hiB);
        check("sync begin shift", 256, riseB - riseA);
        $display("test line sync done");
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        rdchk(8'h35, 8'h01);
        check("pal after reset", 32'h85, maxIrePal);
        check("sync out after reset", 32'h0, lineSyncOut);
        $display("test second reset done");
        summarize();
    end
endmodule
